// [rtl/ncob_pkg.sv]
// Shared constants, types and helpers of the numerically controlled oscillator
package ncob_pkg;

  // Datapath widths
  localparam int unsigned ACC_W    = 20;
  localparam int unsigned PWS_W    = 3;
  localparam int unsigned REM_W    = 7;

  // Register byte addresses on the bus
  localparam logic [7:0] OFF_CON   = 8'h00;
  localparam logic [7:0] OFF_CLK   = 8'h04;
  localparam logic [7:0] OFF_ACCL  = 8'h08;
  localparam logic [7:0] OFF_ACCH  = 8'h0c;
  localparam logic [7:0] OFF_ACCU  = 8'h10;
  localparam logic [7:0] OFF_INCL  = 8'h14;
  localparam logic [7:0] OFF_INCH  = 8'h18;
  localparam logic [7:0] OFF_INCU  = 8'h1c;
  localparam logic [7:0] OFF_ISTAT = 8'h20;
  localparam logic [7:0] OFF_IMASK = 8'h24;

  // Control register field positions
  localparam int unsigned CON_EN   = 7;
  localparam int unsigned CON_OUT  = 5;
  localparam int unsigned CON_POL  = 4;
  localparam int unsigned CON_PFM  = 0;
  // Clock register field positions
  localparam int unsigned CLK_PWS  = 5;
  localparam int unsigned CLK_CKS  = 0;
  // Interrupt status and mask field position
  localparam int unsigned IRQ_OVF  = 0;

  // Reset values
  localparam logic [7:0] RST_CON   = 8'h00;
  localparam logic [7:0] RST_CLK   = 8'h00;
  localparam logic [7:0] RST_INCL  = 8'h01;
  localparam logic [7:0] RST_INCH  = 8'h00;
  localparam logic [7:0] RST_INCU  = 8'h00;
  localparam logic [ACC_W-1:0] RST_ACC = 20'h00000;

  // Clock source select codes, the fourth code is reserved
  localparam logic [1:0] CKS_FAST  = 2'h0;
  localparam logic [1:0] CKS_SYS   = 2'h1;
  localparam logic [1:0] CKS_CELL  = 2'h2;

  // Pulse stage states
  typedef enum logic [1:0] {
    PS_IDLE   = 2'h1,
    PS_ACTIVE = 2'h2
  } ncob_pstate_t;

  // Pads a four-bit upper field into a byte, top nibble zero
  function automatic logic [7:0] ncob_nibble(input logic [3:0] n);
    return {4'h0, n};
  endfunction

  // Last count of an active pulse: two to the select, minus one
  function automatic logic [REM_W-1:0] ncob_width_last(
    input logic [PWS_W-1:0] pws);
    logic [7:0] w;
    w = 8'h01 << pws;
    return REM_W'(w - 8'h01);
  endfunction

endpackage

// [rtl/ncob_clk_sel.sv]
// Input clock source selection and edge detection for the oscillator
`timescale 1ns/10ps
module ncob_clk_sel
  import ncob_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  // Candidate sources, synchronous to clock_in
  input  wire logic       internal_fast_oscillator_in,
  input  wire logic       system_oscillator_in,
  input  wire logic       logic_cell_output_in,
  input  wire logic [1:0] clock_source_select_in,
  // Edge pulses of the selected source
  output logic            rise_out,
  output logic            fall_out
);

  typedef struct packed {
    logic prev;
  } ncob_csel_t;

  ncob_csel_t s_q;
  ncob_csel_t s_d;
  logic       src;

  // source mux
  // Reserved code gives a still clock so the accumulator freezes
  always_comb begin
    case (clock_source_select_in)
      CKS_FAST: src = internal_fast_oscillator_in;
      CKS_SYS:  src = system_oscillator_in;
      CKS_CELL: src = logic_cell_output_in;
      default:  src = 1'b0;
    endcase
    s_d.prev = src;
  end

  // Previous level of the selected source
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Edge pulses, one system cycle each
  // reserved code gates both edges
  // Without the gate, switching to the reserved code while high gives a fall
  assign rise_out = src & ~s_q.prev & ~(&clock_source_select_in);
  assign fall_out = ~src & s_q.prev & ~(&clock_source_select_in);

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_reserved_still: assert property (
    (clock_source_select_in == 2'h3) |-> !rise_out && !fall_out)
    else $error("reserved clock source produced an edge");

endmodule

// [rtl/ncob_pulse.sv]
// Output stage: toggle or stretched pulse, then polarity
`timescale 1ns/10ps
module ncob_pulse
  import ncob_pkg::*;
(
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Controls
  input  wire logic             module_enable_in,
  input  wire logic             pulse_frequency_select_in,
  input  wire logic             output_polarity_in,
  input  wire logic [PWS_W-1:0] pulse_width_select_in,
  // Events from the accumulator
  input  wire logic             tick_in,
  input  wire logic             overflow_in,
  // Final output
  output logic                  wave_out
);

  typedef struct packed {
    ncob_pstate_t     pst;
    logic             pend;
    logic [REM_W-1:0] rem;
    logic             fdc;
    logic             out;
  } ncob_pulse_t;

  ncob_pulse_t s_q;
  ncob_pulse_t s_d;
  logic        level;

  // Next state of the shaper
  always_comb begin
    s_d = s_q;
    if (!module_enable_in) begin
      s_d.pst  = PS_IDLE;
      s_d.pend = 1'b0;
      s_d.rem  = '0;
      s_d.fdc  = 1'b0;
    end else if (tick_in) begin
      s_d.pend = overflow_in;
      if (!pulse_frequency_select_in) begin
        if (overflow_in) begin
          s_d.fdc = ~s_q.fdc;
        end
      end else begin
        case (s_q.pst)
          PS_IDLE: begin
            if (s_q.pend) begin
              s_d.pst = PS_ACTIVE;
              s_d.rem = ncob_width_last(pulse_width_select_in);
            end
          end
          PS_ACTIVE: begin
            if (s_q.pend) begin
              s_d.rem = ncob_width_last(pulse_width_select_in);
            end else if (s_q.rem == '0) begin
              s_d.pst = PS_IDLE;
            end else begin
              s_d.rem = s_q.rem - 1'b1;
            end
          end
          default: s_d.pst = PS_IDLE;
        endcase
      end
    end
    level = pulse_frequency_select_in ? (s_d.pst == PS_ACTIVE) : s_d.fdc;
    s_d.out = level ^ output_polarity_in;
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q     <= '0;
      s_q.pst <= PS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wave_out = s_q.out;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_pf_start: assert property (
    module_enable_in && pulse_frequency_select_in && tick_in && s_q.pend
    |=> s_q.pst == PS_ACTIVE &&
        s_q.rem == ncob_width_last($past(pulse_width_select_in)))
    else $error("pulse did not start with the selected width");

  a_pf_expire: assert property (
    module_enable_in && pulse_frequency_select_in && tick_in &&
    !s_q.pend && s_q.pst == PS_ACTIVE && s_q.rem == '0
    |=> s_q.pst == PS_IDLE)
    else $error("pulse did not end when its width expired");

  a_fdc_toggle: assert property (
    module_enable_in && !pulse_frequency_select_in && tick_in && overflow_in
    |=> s_q.fdc != $past(s_q.fdc) && s_q.pst == $past(s_q.pst))
    else $error("fixed duty output failed to toggle on overflow");

  a_pol_output: assert property (
    ##1 wave_out == ($past(level) ^ $past(output_polarity_in)))
    else $error("output does not follow level and polarity");

  c_pf_pulse: cover property (
    s_q.pst == PS_ACTIVE ##1 s_q.pst == PS_IDLE);

endmodule

// [rtl/ncob_top.sv]
// Numerically controlled oscillator with classic Wishbone register slave
`timescale 1ns/10ps
module ncob_top
  import ncob_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // Oscillator input clock sources
  input  wire logic        internal_fast_oscillator_in,
  input  wire logic        system_oscillator_in,
  input  wire logic        logic_cell_output_in,
  // Results
  output logic             wave_out,
  output logic             irq_out
);

  typedef struct packed {
    logic             en;
    logic             pol;
    logic             pfm;
    logic [PWS_W-1:0] pws;
    logic [1:0]       cks;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] inc;
    logic [ACC_W-1:0] shadow;
    logic             pend;
    logic             istat;
    logic             imask;
    logic             ack;
    logic [31:0]      rdata;
  } ncob_regs_t;

  ncob_regs_t     s_q;
  ncob_regs_t     s_d;
  logic [1:0]     rst_sync_q;
  logic           rst_n;
  logic           rise;
  logic           fall;
  logic           req;
  logic           wr_en;
  logic [7:0]     wbyte;
  logic [7:0]     rbyte;
  logic [ACC_W:0] acc_sum;
  logic           ovf;
  logic           wr_incl;

  // Reset release through two flops; assertion is immediate
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Edges of the selected oscillator input clock
  ncob_clk_sel u_clk_sel (
    .clock_in                    (clock_in),
    .rst_n_in                    (rst_n),
    .internal_fast_oscillator_in (internal_fast_oscillator_in),
    .system_oscillator_in        (system_oscillator_in),
    .logic_cell_output_in        (logic_cell_output_in),
    .clock_source_select_in      (s_q.cks),
    .rise_out                    (rise),
    .fall_out                    (fall)
  );

  // Output shaping and polarity
  ncob_pulse u_pulse (
    .clock_in                  (clock_in),
    .rst_n_in                  (rst_n),
    .module_enable_in          (s_q.en),
    .pulse_frequency_select_in (s_q.pfm),
    .output_polarity_in        (s_q.pol),
    .pulse_width_select_in     (s_q.pws),
    .tick_in                   (rise & s_q.en),
    .overflow_in               (ovf),
    .wave_out                  (wave_out)
  );

  // Bus decode: request phase reads, ack phase writes
  assign req     = wb_cyc_in & wb_stb_in;
  assign wr_en   = req & wb_we_in & s_q.ack & wb_sel_in[0];
  assign wbyte   = wb_dat_in[7:0];
  assign wr_incl = wr_en & (wb_adr_in == OFF_INCL);
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, s_q.shadow};

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rbyte = 8'h00;
    case (wb_adr_in)
      OFF_CON: begin
        rbyte[CON_EN]  = s_q.en;
        rbyte[CON_OUT] = wave_out;
        rbyte[CON_POL] = s_q.pol;
        rbyte[CON_PFM] = s_q.pfm;
      end
      OFF_CLK: begin
        rbyte[CLK_PWS +: PWS_W] = s_q.pws;
        rbyte[CLK_CKS +: 2]     = s_q.cks;
      end
      OFF_ACCL:  rbyte = s_q.acc[7:0];
      OFF_ACCH:  rbyte = s_q.acc[15:8];
      OFF_ACCU:  rbyte = ncob_nibble(s_q.acc[19:16]);
      OFF_INCL:  rbyte = s_q.inc[7:0];
      OFF_INCH:  rbyte = s_q.inc[15:8];
      OFF_INCU:  rbyte = ncob_nibble(s_q.inc[19:16]);
      OFF_ISTAT: rbyte[IRQ_OVF] = s_q.istat;
      OFF_IMASK: rbyte[IRQ_OVF] = s_q.imask;
      default:   rbyte = 8'h00;
    endcase
  end

  // Next state of the register file and datapath
  always_comb begin
    s_d = s_q;
    ovf = 1'b0;
    // Ack one cycle after the request, dropped the cycle after
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdata = {24'h000000, rbyte};
    end
    if (s_q.en & rise) begin
      s_d.acc = acc_sum[ACC_W-1:0];
      ovf     = acc_sum[ACC_W];
    end
    // Software writes; an accumulator write wins over the adder
    if (wr_en) begin
      case (wb_adr_in)
        OFF_CON: begin
          s_d.en  = wbyte[CON_EN];
          s_d.pol = wbyte[CON_POL];
          s_d.pfm = wbyte[CON_PFM];
        end
        OFF_CLK: begin
          s_d.pws = wbyte[CLK_PWS +: PWS_W];
          s_d.cks = wbyte[CLK_CKS +: 2];
        end
        OFF_ACCL:  s_d.acc[7:0]   = wbyte;
        OFF_ACCH:  s_d.acc[15:8]  = wbyte;
        OFF_ACCU:  s_d.acc[19:16] = wbyte[3:0];
        OFF_INCL:  s_d.inc[7:0]   = wbyte;
        OFF_INCH:  s_d.inc[15:8]  = wbyte;
        OFF_INCU:  s_d.inc[19:16] = wbyte[3:0];
        OFF_IMASK: s_d.imask      = wbyte[IRQ_OVF];
        default:   s_d.imask      = s_q.imask;
      endcase
    end
    if (!s_q.en) begin
      s_d.shadow = s_d.inc;
      s_d.pend   = 1'b0;
    end else begin
      if (fall & s_q.pend) begin
        s_d.shadow = s_q.inc;
      end
      s_d.pend = wr_incl | (s_q.pend & ~fall);
    end
    s_d.istat = (s_q.istat &
                 ~(wr_en & (wb_adr_in == OFF_ISTAT) & wbyte[IRQ_OVF])) | ovf;
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.en     <= RST_CON[CON_EN];
      s_q.pol    <= RST_CON[CON_POL];
      s_q.pfm    <= RST_CON[CON_PFM];
      s_q.pws    <= RST_CLK[CLK_PWS +: PWS_W];
      s_q.cks    <= RST_CLK[CLK_CKS +: 2];
      s_q.acc    <= RST_ACC;
      s_q.inc    <= {RST_INCU[3:0], RST_INCH, RST_INCL};
      s_q.shadow <= {RST_INCU[3:0], RST_INCH, RST_INCL};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus and interrupt outputs; the interrupt needs the module enabled
  assign wb_dat_out = s_q.rdata;
  assign wb_ack_out = s_q.ack;
  assign irq_out    = s_q.en & s_q.istat & s_q.imask;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  a_acc_adds: assert property (
    s_q.en && rise && !wr_en
    |=> s_q.acc == $past(acc_sum[ACC_W-1:0]))
    else $error("accumulator did not add the working increment");

  a_ovf_flag: assert property (
    ovf |=> s_q.istat ##1 (s_q.istat || $past(wr_en)))
    else $error("overflow flag not set or lost without a clear");

  a_shadow_fall: assert property (
    s_q.en && fall && s_q.pend |=> s_q.shadow == $past(s_q.inc))
    else $error("working increment not loaded on falling edge");

  a_shadow_wait: assert property (
    s_q.en && !s_q.pend && !(fall && s_q.pend)
    |=> s_q.shadow == $past(s_q.shadow))
    else $error("working increment changed without a pending load");

  a_shadow_off: assert property (
    !s_q.en |=> s_q.shadow == s_q.inc)
    else $error("disabled oscillator did not copy the increment");

  a_upper_nibble: assert property (
    req && !s_q.ack && (wb_adr_in == OFF_ACCU || wb_adr_in == OFF_INCU)
    |=> wb_ack_out && wb_dat_out[7:4] == 4'h0)
    else $error("upper register read a nonzero top nibble");

  a_clk_gap: assert property (
    req && !s_q.ack && wb_adr_in == OFF_CLK
    |=> wb_ack_out && wb_dat_out[4:2] == 3'h0)
    else $error("clock register unused bits not zero");

  a_reset_inc: assert property (
    $rose(rst_n) |-> s_q.inc == 20'h00001 && s_q.acc == RST_ACC)
    else $error("reset values of increment or accumulator wrong");

  a_ack_once: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  c_overflow:  cover property (ovf);
  c_irq_fire:  cover property (irq_out);
  c_shadow_ld: cover property (s_q.en && fall && s_q.pend);
  c_pf_run:    cover property (s_q.en && s_q.pfm && ovf);

endmodule

// [tb/test_numerically_controlled_oscillator.sv]
// Self-checking bench for the numerically controlled oscillator
`timescale 1ns/10ps
module test_numerically_controlled_oscillator
  import ncob_pkg::*;
;
  logic        clock_in;
  logic        nrst_in;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        wave;
  logic        irq;
  logic [1:0]  src_pick;
  logic [1:0]  src_ph;
  logic        src_lvl;
  logic        wave_prev;
  logic        cnt_clr;
  int          src_load;
  logic [31:0] v;
  logic [19:0] e;
  int          src_left;
  int          rises;
  int          highs;
  int          errors;
  int          checked;

  // Rows: write flag, address, write data, expected read
  localparam int NROW = 19;
  localparam logic [31:0] ROWS [NROW] = '{
    32'h00_00_00_00, 32'h00_04_00_00, 32'h00_08_00_00, 32'h00_0c_00_00,
    32'h00_10_00_00, 32'h00_14_00_01, 32'h00_18_00_00, 32'h00_1c_00_00,
    32'h00_20_00_00, 32'h00_24_00_00, 32'h00_28_00_00, 32'h01_04_ff_e3,
    32'h01_1c_ff_0f, 32'h01_10_ff_0f, 32'h01_0c_a5_a5, 32'h01_18_5a_5a,
    32'h01_28_ff_00, 32'h01_00_11_31, 32'h01_24_01_01};
  // Output rows: mode, width code, wave rises, end level, high cycles
  localparam logic [31:0] PFR [6] = '{
    32'h01_00_20_08, 32'h01_01_20_10, 32'h01_02_20_20, 32'h01_03_20_40,
    32'h01_07_11_00, 32'h00_07_10_40};

  ncob_top i_dut (
    .clock_in                    (clock_in),
    .nrst_in                     (nrst_in),
    .wb_cyc_in                   (wb_cyc),
    .wb_stb_in                   (wb_stb),
    .wb_we_in                    (wb_we),
    .wb_adr_in                   (wb_adr),
    .wb_sel_in                   (wb_sel),
    .wb_dat_in                   (wb_wdat),
    .wb_dat_out                  (wb_rdat),
    .wb_ack_out                  (wb_ack),
    .internal_fast_oscillator_in (src_lvl && src_pick != 2'h1 &&
                                  src_pick != 2'h2),
    .system_oscillator_in        (src_lvl && src_pick[0]),
    .logic_cell_output_in        (src_lvl && src_pick[1]),
    .wave_out                    (wave),
    .irq_out                     (irq)
  );

  // 40 MHz system clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Source pulses two cycles high, two low; still when no pulses are due
  always @(posedge clock_in) begin
    if (!nrst_in) begin
      src_left <= 0;
      src_ph   <= 2'h0;
    end else if (src_load > 0) begin
      src_left <= src_load;
    end else if (src_left > 0) begin
      src_ph <= src_ph + 2'h1;
      if (src_ph == 2'h3) begin
        src_left <= src_left - 1;
      end
    end
  end
  assign src_lvl = (src_left > 0) && (src_ph < 2'h2);

  // Count output rises and high cycles
  always @(posedge clock_in) begin
    wave_prev <= wave;
    if (cnt_clr) begin
      rises <= 0;
      highs <= 0;
    end else begin
      if (wave === 1'b1 && wave_prev === 1'b0) rises <= rises + 1;
      if (wave === 1'b1) highs <= highs + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One classic bus cycle; waits for ack under a bound
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [7:0] wd);
    int n;
    @(posedge clock_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    if (n >= 64) begin
      errors++;
      results();
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    xfer(1'b1, adr, d);
  endtask

  task automatic rd(input logic [7:0] adr);
    xfer(1'b0, adr, 8'h00);
  endtask

  // Run n source periods, then let the pipeline settle
  task automatic pulses(input int n);
    int k;
    @(posedge clock_in);
    src_load <= n;
    @(posedge clock_in);
    src_load <= 0;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (src_left != 0 && k < 4000);
    if (k >= 4000) begin
      errors++;
      results();
    end
    repeat (4) @(posedge clock_in);
  endtask

  task automatic setup(input logic [19:0] inc, input logic [7:0] clk);
    wr(OFF_CON, 8'h00);
    wr(OFF_ACCL, 8'h00);
    wr(OFF_ACCH, 8'h00);
    wr(OFF_ACCU, 8'h00);
    wr(OFF_INCU, {4'h0, inc[19:16]});
    wr(OFF_INCH, inc[15:8]);
    wr(OFF_INCL, inc[7:0]);
    wr(OFF_CLK, clk);
  endtask

  initial begin
    nrst_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h1;
    wb_wdat = 32'h0;
    src_load = 0;
    src_pick = 2'h0;
    cnt_clr = 1'b1;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    // Reset values, reserved bits, nibble registers, unmapped place
    for (int i = 0; i < NROW; i++) begin
      if (ROWS[i][24]) wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16]);
      check(v, {24'h0, ROWS[i][7:0]});
    end
    // Only the selected source advances the sum
    for (int c = 0; c < 4; c++) begin
      setup(20'h0fff0, 8'(c));
      wr(OFF_CON, 8'h80);
      if (c < 3) begin
        src_pick <= 2'((c + 1) % 3);
        pulses(3);
      end
      src_pick <= 2'(c);
      pulses(5);
      e = (c < 3) ? 20'h0fff0 * 20'd5 : 20'h00000;
      rd(OFF_ACCL);
      check(v, {24'h0, e[7:0]});
      rd(OFF_ACCH);
      check(v, {24'h0, e[15:8]});
      rd(OFF_ACCU);
      check(v, {28'h0, e[19:16]});
    end
    // New increment applies after a source falling edge
    setup(20'h00010, 8'h01);
    src_pick <= 2'h1;
    wr(OFF_CON, 8'h80);
    wr(OFF_INCU, 8'h00);
    wr(OFF_INCH, 8'h00);
    wr(OFF_INCL, 8'h20);
    pulses(1);
    pulses(1);
    rd(OFF_ACCL);
    check(v, 32'h30);
    // Sticky flag, mask, clear and polarity
    setup(20'h80000, 8'h01);
    wr(OFF_IMASK, 8'h01);
    wr(OFF_CON, 8'h80);
    pulses(1);
    check({31'h0, irq}, 32'h0);
    pulses(1);
    check({31'h0, irq}, 32'h1);
    check({31'h0, wave}, 32'h1);
    rd(OFF_CON);
    check(v, 32'ha0);
    wr(OFF_ISTAT, 8'h01);
    repeat (2) @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    wr(OFF_IMASK, 8'h00);
    pulses(2);
    check({30'h0, irq, wave}, 32'h0);
    rd(OFF_ISTAT);
    check(v, 32'h1);
    wr(OFF_IMASK, 8'h01);
    repeat (2) @(posedge clock_in);
    check({31'h0, irq}, 32'h1);
    wr(OFF_CON, 8'h90);
    repeat (3) @(posedge clock_in);
    check({31'h0, wave}, 32'h1);
    // Pulse widths, width ignored in toggle mode, long width
    for (int i = 0; i < 6; i++) begin
      setup(20'h10000, {PFR[i][18:16], 5'h01});
      cnt_clr <= 1'b1;
      @(posedge clock_in);
      cnt_clr <= 1'b0;
      wr(OFF_CON, {7'h40, PFR[i][24]});
      pulses(44);
      check(32'(rises), {28'h0, PFR[i][15:12]});
      check({31'h0, wave}, {31'h0, PFR[i][8]});
      if (PFR[i][7:0] != 8'h00) check(32'(highs), {24'h0, PFR[i][7:0]});
    end
    wr(OFF_INCL, 8'h55);
    @(posedge clock_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    check({30'h0, irq, wave}, 32'h0);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(OFF_INCL);
    check(v, 32'h01);
    rd(OFF_CON);
    check(v, 32'h00);
    // Write with byte lane zero disabled is ignored
    wb_sel <= 4'h0;
    wr(OFF_INCH, 8'h77);
    wb_sel <= 4'h1;
    rd(OFF_INCH);
    check(v, 32'h00);
    results();
  end
endmodule
